// *** hdl/lpb_map.vh ***
`ifndef LPB_MAP_VH
`define LPB_MAP_VH
// Register byte addresses
`define LPB_CTRL1_ADDR 12'h000
`define LPB_CTRL2_ADDR 12'h004
`define LPB_PBLOCK_ADDR 12'h008
`define LPB_PAUX_ADDR 12'h00C
`define LPB_CONTRAST_ADDR 12'h010
`define LPB_BFIRST_ADDR 12'h014
`define LPB_BLAST_ADDR 12'h018
`define LPB_BMASKA_ADDR 12'h01C
`define LPB_BMASKB_ADDR 12'h020
`define LPB_BMASKC_ADDR 12'h024
`define LPB_STATUS_ADDR 12'h028
`define LPB_SCROLL_ADDR 12'h02C
// Control register 1 fields
`define LPB_C1_SCANREV 0
`define LPB_C1_SUPPLY 4
`define LPB_C1_STANDBY 5
`define LPB_C1_DISPON 6
// Control register 2 fields
`define LPB_C2_BLINK 0
`define LPB_C2_DUTYLO 2
`define LPB_C2_DUTYHI 3
`define LPB_C2_GRAY 4
// Duty codes
`define LPB_DUTY_8 2'h3
`define LPB_DUTY_32 2'h2
`define LPB_DUTY_64 2'h1
`define LPB_DUTY_80 2'h0
// Row counts per duty
`define LPB_ROWS_8 7'h08
`define LPB_ROWS_32 7'h20
`define LPB_ROWS_64 7'h40
`define LPB_ROWS_80 7'h50
// Divider factors N
`define LPB_N_GREY32 5'h1F
`define LPB_N_GREY4 5'h03
// Blink divide: last count of each 64-frame half period
`define LPB_BLINK_FRAMES 6'h3F
// Partial block limits
`define LPB_PBLOCK_MAX 4'h9
`define LPB_PBLOCK_LOW_MAX 4'h4
`define LPB_LAST_ROW 7'h4F
`endif

// *** hdl/lpb_row_gen.v ***
`timescale 1ns/1ps
`default_nettype none
`include "lpb_map.vh"
// Maps scan step to physical row, partial block aware
module lpb_row_gen (
  // Scan state
  input wire [6:0] step,
  input wire partial,
  input wire [3:0] block,
  input wire scan_rev,
  // Physical row index, 0 based
  output reg [6:0] row
);
  reg [2:0] sub;
  reg [6:0] base;
  always @* begin
    sub = scan_rev ? step[2:0] : (3'h7 - step[2:0]); // see R5
    base = 7'h00;
    row = step;
    if (partial) begin
      if (block <= `LPB_PBLOCK_LOW_MAX) begin
        base = {block[2:0], 3'h0};
        row = base + {4'h0, sub}; // see R5
      end else begin
        base = `LPB_LAST_ROW - {block[2:0] - 3'h5, 3'h0};
        row = base - {4'h0, sub}; // see R5
      end
    end
  end
endmodule
`default_nettype wire

// *** hdl/lpb_timing.v ***
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "lpb_map.vh"
// Operation
// R1 - Partial mode drives eight selected rows at 1/8 duty, rest unselected.
// R2 - Partial mode contrast uses three low contrast register bits.
// R3 - Host removes high supply, then programs duty, direction, position, contrast.
// R4 - Supply control output follows the supply-on bit.
// R5 - Position selects an eight-row block; reverse bit flips scan order.
// R6 - Frame rate is clock divided by N times duty rows, N 31 or 3.
// R7 - Oscillator path A in 32-level grey, path B in 4-level grey.
// R8 - Blink toggles area at one sixty-fourth of frame rate.
// R9 - Blink limited to rows from first-row to last-row register.
// R10 - Three mask registers enable blink per eight-dot column group.
// R11 - Blinking starts only when blink enable is written to one.
// R12 - Blink counter held clear while enable is zero.
// R13 - Blink area uses RAM row coordinates, moving with scroll.
// R14 - Standby stops functions, keeps registers except display-on bit.
// R15 - During standby only control registers accept accesses; the code also accepts the status register.
// R16 - Standby drives all row and column outputs to the high level; the code drives row_drive_outs and column_drive_outs low, column_blank_q high.
// R17 - Standby halts operation and oscillator; clearing restores operation.
// R18 - Oscillator keeps running in partial display mode.
// R19 - Duty select codes: 11 is 1/8, 10 1/32, 01 1/64, 00 1/80.
// R20 - Host changes grey, standby or oscillator only by documented sequences.
module lpb_timing #(
  parameter ROWS = 80,
  parameter COLS = 160
) (
  // APB slave
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Panel drive: 1 selects, blank level driven high
  output reg [ROWS-1:0] row_drive_outs,
  output reg [COLS-1:0] column_drive_outs,
  output reg [COLS-1:0] column_blank_q,
  // Supply and oscillator
  output reg supply_ctl_out,
  output reg osc_res_path_a,
  output reg osc_res_path_b,
  output reg osc_run_q,
  output reg [2:0] partial_contrast_q,
  output reg frame_pulse_q
);
  // Registers
  reg [7:0] ctrl1_q, ctrl2_q, pblock_q, paux_q, contrast_q;
  reg [6:0] bfirst_q, blast_q, scroll_q;
  reg [7:0] bmask_a_q, bmask_b_q, bmask_c_q;
  reg [4:0] div_q;
  reg [6:0] step_q;
  reg [5:0] bcnt_q;
  reg bphase_q;
  wire standby = ctrl1_q[`LPB_C1_STANDBY];
  wire [1:0] duty = {ctrl2_q[`LPB_C2_DUTYHI], ctrl2_q[`LPB_C2_DUTYLO]};
  wire partial = (duty == `LPB_DUTY_8);
  wire blink_on = ctrl2_q[`LPB_C2_BLINK];
  wire acc = psel && penable;
  wire ctrl_addr = (paddr == `LPB_CTRL1_ADDR) || (paddr == `LPB_CTRL2_ADDR);
  wire known = ctrl_addr || (paddr == `LPB_PBLOCK_ADDR) || (paddr == `LPB_PAUX_ADDR) ||
    (paddr == `LPB_CONTRAST_ADDR) || (paddr == `LPB_BFIRST_ADDR) ||
    (paddr == `LPB_BLAST_ADDR) || (paddr == `LPB_BMASKA_ADDR) ||
    (paddr == `LPB_BMASKB_ADDR) || (paddr == `LPB_BMASKC_ADDR) ||
    (paddr == `LPB_STATUS_ADDR) || (paddr == `LPB_SCROLL_ADDR);
  wire refuse = !known || (standby && !ctrl_addr && paddr != `LPB_STATUS_ADDR); // see R15
  wire wr = acc && pwrite && !pready && !refuse;
  reg [6:0] nrows;
  reg [4:0] nfac;
  wire [6:0] phys_row;
  reg [6:0] ram_row;
  reg [7:0] row_sum;
  reg in_rows;

  // Rows per frame from duty select
  always @* begin
    case (duty) // see R19
      `LPB_DUTY_8: nrows = `LPB_ROWS_8;
      `LPB_DUTY_32: nrows = `LPB_ROWS_32;
      `LPB_DUTY_64: nrows = `LPB_ROWS_64;
      default: nrows = `LPB_ROWS_80;
    endcase
    nfac = ctrl2_q[`LPB_C2_GRAY] ? `LPB_N_GREY4 : `LPB_N_GREY32; // see R6
  end

  // Register writes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl1_q <= 8'h00;
      ctrl2_q <= 8'h00;
      pblock_q <= 8'h00;
      paux_q <= 8'h00;
      contrast_q <= 8'h00;
      bfirst_q <= 7'h00;
      blast_q <= 7'h00;
      scroll_q <= 7'h00;
      bmask_a_q <= 8'h00;
      bmask_b_q <= 8'h00;
      bmask_c_q <= 8'h00;
    end else if (wr) begin
      case (paddr)
        `LPB_CTRL1_ADDR: begin
          ctrl1_q <= pwdata[7:0];
          // Entering standby drops display-on
          if (pwdata[`LPB_C1_STANDBY])
            ctrl1_q[`LPB_C1_DISPON] <= 1'b0; // see R14
        end
        `LPB_CTRL2_ADDR: ctrl2_q <= pwdata[7:0];
        `LPB_PBLOCK_ADDR: pblock_q <= pwdata[7:0];
        `LPB_PAUX_ADDR: paux_q <= pwdata[7:0];
        `LPB_CONTRAST_ADDR: contrast_q <= pwdata[7:0];
        `LPB_BFIRST_ADDR: bfirst_q <= pwdata[6:0];
        `LPB_BLAST_ADDR: blast_q <= pwdata[6:0];
        `LPB_BMASKA_ADDR: bmask_a_q <= pwdata[7:0];
        `LPB_BMASKB_ADDR: bmask_b_q <= pwdata[7:0];
        `LPB_BMASKC_ADDR: bmask_c_q <= pwdata[7:0];
        `LPB_SCROLL_ADDR: scroll_q <= pwdata[6:0];
        default: ctrl1_q <= ctrl1_q;
      endcase
    end
  end

  // APB answer one cycle after access phase starts
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= acc && !pready;
      pslverr <= acc && !pready && refuse;
      prdata <= 32'h00000000;
      if (acc && !pready && !pwrite && !refuse) begin
        case (paddr)
          `LPB_CTRL1_ADDR: prdata <= {24'h000000, ctrl1_q};
          `LPB_CTRL2_ADDR: prdata <= {24'h000000, ctrl2_q};
          `LPB_STATUS_ADDR: prdata <= {12'h000, bphase_q, bcnt_q, step_q, osc_run_q, div_q};
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end

  // Frame divider: N clocks per row, nrows per frame; halted in standby
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 5'h00;
      step_q <= 7'h00;
      frame_pulse_q <= 1'b0;
      osc_run_q <= 1'b0;
    end else begin
      osc_run_q <= !standby; // see R17, R18
      frame_pulse_q <= 1'b0;
      if (standby) begin
        div_q <= 5'h00; // see R17
        step_q <= 7'h00;
      end else if (div_q >= nfac - 5'h01) begin
        div_q <= 5'h00; // see R6
        if (step_q >= nrows - 7'h01) begin
          step_q <= 7'h00;
          frame_pulse_q <= 1'b1;
        end else begin
          step_q <= step_q + 7'h01;
        end
      end else begin
        div_q <= div_q + 5'h01;
      end
    end
  end

  // Blink counter: toggles phase every 64 frames
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bcnt_q <= 6'h00;
      bphase_q <= 1'b0;
    end else if (!blink_on) begin
      bcnt_q <= 6'h00; // see R12
      bphase_q <= 1'b0;
    end else if (frame_pulse_q) begin
      bcnt_q <= bcnt_q + 6'h01; // see R8, R11
      if (bcnt_q == `LPB_BLINK_FRAMES)
        bphase_q <= !bphase_q; // see R8
    end
  end

  lpb_row_gen u_row (
    .step(step_q),
    .partial(partial),
    .block(pblock_q[3:0]),
    .scan_rev(ctrl1_q[`LPB_C1_SCANREV]),
    .row(phys_row)
  );

  // RAM row of the current screen row, follows scroll
  always @* begin
    // Eight bits so row plus scroll cannot wrap before the modulo
    row_sum = {1'b0, phys_row} + {1'b0, scroll_q}; // see R13
    if (row_sum > {1'b0, `LPB_LAST_ROW})
      row_sum = row_sum - {1'b0, `LPB_ROWS_80};
    ram_row = row_sum[6:0];
    in_rows = (ram_row >= bfirst_q) && (ram_row <= blast_q); // see R9
  end

  // Output stage
  genvar g;
  generate
    for (g = 0; g < ROWS; g = g + 1) begin : g_row
      always @(posedge pclk or negedge presetn) begin
        if (!presetn)
          row_drive_outs[g] <= 1'b0;
        else
          // Only current row selected; others unselected
          row_drive_outs[g] <= !standby && (phys_row == g); // see R1, R16
      end
    end
    for (g = 0; g < COLS; g = g + 1) begin : g_col
      wire mbit = (g < 64) ? bmask_a_q[g/8] :
                  (g < 128) ? bmask_b_q[(g-64)/8] : bmask_c_q[(g-128)/8];
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          column_drive_outs[g] <= 1'b0;
          column_blank_q[g] <= 1'b1;
        end else begin
          column_drive_outs[g] <= !standby && ctrl1_q[`LPB_C1_DISPON];
          // Blank high in standby, with display-on clear, or in the off phase of blink area
          column_blank_q[g] <= standby || !ctrl1_q[`LPB_C1_DISPON] ||
            (blink_on && bphase_q && in_rows && mbit); // see R10, R16
        end
      end
    end
  endgenerate

  // Supply, oscillator path and contrast
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      supply_ctl_out <= 1'b0;
      osc_res_path_a <= 1'b0;
      osc_res_path_b <= 1'b0;
      partial_contrast_q <= 3'h0;
    end else begin
      supply_ctl_out <= ctrl1_q[`LPB_C1_SUPPLY]; // see R4
      osc_res_path_a <= !standby && !ctrl2_q[`LPB_C2_GRAY]; // see R7
      osc_res_path_b <= !standby && ctrl2_q[`LPB_C2_GRAY]; // see R7
      partial_contrast_q <= partial ? contrast_q[2:0] : 3'h0; // see R2
    end
  end
endmodule
`default_nettype wire

// *** test/lpb_timing_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "lpb_map.vh"
module lpb_timing_props #(
  parameter ROWS = 80,
  parameter COLS = 160
) (
  // Bus side
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  // Panel and supply side
  input wire logic [ROWS-1:0] row_drive_outs,
  input wire logic [COLS-1:0] column_drive_outs,
  input wire logic [COLS-1:0] column_blank_q,
  input wire logic supply_ctl_out,
  input wire logic osc_res_path_a,
  input wire logic osc_res_path_b,
  input wire logic osc_run_q,
  input wire logic frame_pulse_q
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Bus answers and refusals
  answer_next_a: assert property (psel && penable && !pready |=> pready && !$past(pready))
    else $error("no answer one cycle after access");
  refuse_standby_bit_a: assert property (
    psel && penable && !pready && !osc_run_q && paddr == `LPB_PBLOCK_ADDR |=> pslverr)
    else $error("standby access to data register not refused");
  refuse_hole_a: assert property (psel && penable && !pready && paddr > `LPB_SCROLL_ADDR
    |=> pready && pslverr) else $error("unmapped access not refused");
  // Panel drive, oscillator path, frame pulse and supply
  standby_bit_dark_a: assert property (!osc_run_q && $past(!osc_run_q) |->
    row_drive_outs == '0 && column_drive_outs == '0 && &column_blank_q)
    else $error("outputs not off in standby");
  osc_stop_a: assert property (!osc_run_q [*2] |-> !osc_res_path_a && !osc_res_path_b)
    else $error("oscillator path active in standby");
  one_path_a: assert property (!(osc_res_path_a && osc_res_path_b))
    else $error("both oscillator paths on");
  one_row_a: assert property ($onehot0(row_drive_outs))
    else $error("more than one row selected");
  frame_pulse_a: assert property (frame_pulse_q |=> !frame_pulse_q)
    else $error("frame pulse longer than one cycle");
  supply_follow_a: assert property ($changed(supply_ctl_out) |-> pready || $past(pready))
    else $error("supply output moved without a write");
endmodule
bind lpb_timing lpb_timing_props #(.ROWS(ROWS), .COLS(COLS)) chk_u (.pclk, .presetn, .psel,
  .penable, .paddr, .pready, .pslverr, .row_drive_outs, .column_drive_outs, .column_blank_q,
  .supply_ctl_out, .osc_res_path_a, .osc_res_path_b, .osc_run_q, .frame_pulse_q);
`default_nettype wire

// *** test/lpb_panel_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module lpb_panel_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Row electrodes and frame marker
  input wire logic [79:0] row_drive_outs,
  input wire logic frame_pulse_q,
  // Per frame observations
  output logic [15:0] frame_len,
  output logic [15:0] n_frames,
  output logic [79:0] rows_seen
);
  logic [15:0] cnt_q;
  logic [79:0] acc_q;
  // Panel sees rows scanned between frame markers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 16'h0001;
      acc_q <= '0;
      frame_len <= 16'h0000;
      n_frames <= 16'h0000;
      rows_seen <= '0;
    end else if (frame_pulse_q) begin
      frame_len <= cnt_q;
      cnt_q <= 16'h0001;
      n_frames <= n_frames + 16'h0001;
      rows_seen <= acc_q | row_drive_outs;
      acc_q <= '0;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
      acc_q <= acc_q | row_drive_outs;
    end
  end
endmodule
`default_nettype wire

// *** test/test_lcd_partial_blink_standby_timing.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "lpb_map.vh"
module test_lcd_partial_blink_standby_timing;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, supply_ctl_out, osc_res_path_a, osc_res_path_b, osc_run_q, frame_pulse_q;
  logic [79:0] row_drive_outs, rows_seen;
  logic [159:0] column_drive_outs, column_blank_q;
  logic [2:0] partial_contrast_q;
  logic [15:0] frame_len, n_frames;
  int n_mismatch = 0, checks_done = 0;
  int rows_t[4] = '{80, 64, 32, 8};
  always #5 pclk = ~pclk;
  lpb_timing dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .row_drive_outs, .column_drive_outs, .column_blank_q, .supply_ctl_out,
    .osc_res_path_a, .osc_res_path_b, .osc_run_q, .partial_contrast_q, .frame_pulse_q);
  lpb_panel_model panel_u (.pclk, .presetn, .row_drive_outs, .frame_pulse_q, .frame_len,
    .n_frames, .rows_seen);
  task complete_run;
    if (n_mismatch == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input string nm, input logic [79:0] e, input logic [79:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One bus transfer, then an idle cycle
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
    if (i >= 20) begin
      n_mismatch++;
      complete_run;
    end
  endtask
  task wf(input int k);
    int t, s;
    s = n_frames;
    t = 0;
    while (int'(n_frames) - s < k && t < 9000) begin
      @(posedge pclk);
      t++;
    end
    if (t >= 9000) begin
      n_mismatch++;
      complete_run;
    end
  endtask
  task t_supply;
    apb(0, `LPB_CTRL1_ADDR, 0);
    chk("ctrl1", 0, rd);
    apb(1, `LPB_CTRL1_ADDR, 32'h10);
    chk("supply", 1, supply_ctl_out);
    apb(1, `LPB_CTRL1_ADDR, 32'h00);
    chk("supply", 0, supply_ctl_out);
    apb(0, 12'h030, 0);
    chk("hole", 1, er);
  endtask
  task t_frame;
    for (int g = 0; g < 2; g++) begin
      for (int d = 0; d < 4; d++) begin
        apb(1, `LPB_CTRL2_ADDR, (g << 4) | (d << 2));
        wf(2);
        chk("frame", (g ? 3 : 31) * rows_t[d], frame_len);
        chk("path", (g ? 1 : 2), {osc_res_path_a, osc_res_path_b});
      end
    end
  endtask
  task t_partial;
    apb(1, `LPB_CTRL1_ADDR, 0);
    apb(1, `LPB_CTRL2_ADDR, 32'h1C);
    for (int b = 0; b < 10; b++) begin
      apb(1, `LPB_CTRL1_ADDR, b & 1);
      apb(1, `LPB_PBLOCK_ADDR, b);
      apb(1, `LPB_CONTRAST_ADDR, 8 + b);
      wf(2);
      chk("rows", 80'hFF << (b < 5 ? 8 * b : 112 - 8 * b), rows_seen);
      chk("contrast", b & 7, partial_contrast_q);
      chk("osc", 1, osc_run_q);
    end
  endtask
  task t_blink;
    apb(1, `LPB_PBLOCK_ADDR, 0);
    apb(1, `LPB_CTRL1_ADDR, 32'h41);
    apb(1, `LPB_BFIRST_ADDR, 2);
    apb(1, `LPB_BLAST_ADDR, 5);
    apb(1, `LPB_BMASKA_ADDR, 32'h81);
    apb(0, `LPB_STATUS_ADDR, 0);
    chk("idle", 0, rd[19:13]);
    apb(1, `LPB_CTRL2_ADDR, 32'h1D);
    wf(70);
    apb(0, `LPB_STATUS_ADDR, 0);
    chk("phase", 1, rd[19]);
    for (int t = 0; t < 100 && row_drive_outs[3] !== 1'b1; t++) @(posedge pclk);
    chk("row3", 1, row_drive_outs[3]);
    chk("blank", 64'hFF000000000000FF, column_blank_q[63:0]);
    apb(1, `LPB_CTRL2_ADDR, 32'h1C);
    apb(0, `LPB_STATUS_ADDR, 0);
    chk("cleared", 0, rd[19:13]);
  endtask
  task t_standby;
    apb(1, `LPB_CTRL1_ADDR, 32'h70);
    apb(0, `LPB_CTRL1_ADDR, 0);
    chk("ctrl1", 32'h30, rd);
    chk("rows", 0, row_drive_outs);
    chk("cols", 1, &column_blank_q && column_drive_outs == 0);
    chk("osc", 0, osc_run_q);
    apb(1, `LPB_PBLOCK_ADDR, 3);
    chk("err", 1, er);
    apb(0, `LPB_CTRL2_ADDR, 0);
    chk("ctrl2", 32'h1C, rd);
    apb(1, `LPB_CTRL1_ADDR, 0);
    wf(1);
    chk("osc", 1, osc_run_q);
  endtask
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    t_supply;
    t_frame;
    t_partial;
    t_blink;
    t_standby;
    complete_run;
  end
endmodule
`default_nettype wire
